// ==== verilog/cie_pkg.sv ====
`default_nettype none
package cie_pkg;
  localparam int unsigned APB_AW = 12;
  // register byte offsets
  localparam logic [11:0] REG_CMD = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_PC = 12'h008;
  localparam logic [11:0] REG_FLAG = 12'h00c;
  localparam logic [11:0] REG_RET = 12'h010;
  localparam logic [1:0] DATA_WIN_SEL = 2'b01;
  // data space: working registers, then i/o space
  localparam logic [6:0] DATA_IO_OFFSET = 7'h20;
  localparam logic [6:0] DATA_TOP = 7'h5f;
  localparam logic [5:0] IO_BIT_MAX = 6'h1f;
  localparam logic [5:0] IO_FLAG_ADDR = 6'h10;
  // command word fields
  localparam int unsigned CMD_OP_LSB = 0;
  localparam int unsigned CMD_RD_LSB = 6;
  localparam int unsigned CMD_RS_LSB = 11;
  localparam int unsigned CMD_IMM_LSB = 16;
  localparam int unsigned CMD_BIT_LSB = 24;
  localparam int unsigned CMD_LONG_POS = 27;
  // status flag positions
  localparam int unsigned SF_C = 0;
  localparam int unsigned SF_Z = 1;
  localparam int unsigned SF_N = 2;
  localparam int unsigned SF_V = 3;
  localparam int unsigned SF_S = 4;
  localparam int unsigned SF_H = 5;
  localparam int unsigned SF_T = 6;
  localparam logic [7:0] MASK_ARITH = 8'h2f;
  localparam logic [7:0] MASK_LOGIC = 8'h0e;
  localparam logic [7:0] MASK_SHIFT = 8'h0f;
  localparam logic [7:0] MASK_WORD = 8'h1f;
  // reset values and cycle counts
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [31:0] CMD_RST = 32'h0000_0000;
  localparam logic [1:0] CLK_ONE = 2'd1;
  localparam logic [1:0] CLK_TWO = 2'd2;
  localparam logic [1:0] CLK_THREE = 2'd3;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_BUSY = 2'b10} cie_state_e;
  typedef enum logic [5:0] {
    OP_ADD = 6'd0, OP_ADD_CARRY = 6'd1, OP_SUB = 6'd2, OP_SUB_IMM = 6'd3,
    OP_SUB_CARRY_REG = 6'd4, OP_SUB_CARRY_IMM = 6'd5, OP_COMPARE = 6'd6,
    OP_COMPARE_CARRY = 6'd7, OP_COMPARE_IMM = 6'd8, OP_AND = 6'd9,
    OP_AND_IMM = 6'd10, OP_OR = 6'd11, OP_OR_IMM = 6'd12, OP_XOR = 6'd13,
    OP_CLEAR_BITS_MASK = 6'd14, OP_ROTATE_RIGHT_CARRY = 6'd15,
    OP_ARITH_SHIFT_RIGHT = 6'd16, OP_ADD_IMM_WORD = 6'd17,
    OP_SUB_IMM_WORD = 6'd18, OP_COMPARE_SKIP_EQUAL = 6'd19,
    OP_SKIP_REG_BIT_CLEAR = 6'd20, OP_SKIP_REG_BIT_SET = 6'd21,
    OP_SKIP_IO_BIT_CLEAR = 6'd22, OP_SKIP_IO_BIT_SET = 6'd23,
    OP_BRANCH_FLAG_SET = 6'd24, OP_BRANCH_FLAG_CLEAR = 6'd25,
    OP_BRANCH_SIGNED_GE = 6'd26, OP_RELATIVE_JUMP = 6'd27,
    OP_RELATIVE_CALL = 6'd28, OP_INDIRECT_JUMP = 6'd29,
    OP_INDIRECT_CALL = 6'd30, OP_IO_BIT_SET = 6'd31, OP_IO_BIT_CLEAR = 6'd32,
    OP_BIT_TO_TFLAG = 6'd33, OP_TFLAG_TO_BIT = 6'd34, OP_FLAG_SET = 6'd35,
    OP_FLAG_CLEAR = 6'd36
  } cie_op_e;
  localparam logic [5:0] OP_LAST = 6'd36;
endpackage
`default_nettype wire

// ==== verilog/cie_alu.sv ====
`default_nettype none
module cie_alu
  import cie_pkg::*;
(
  input wire cie_op_e op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  output logic [7:0] res,
  output logic res_we,
  output logic [7:0] flag_mask,
  output logic [7:0] flag_val
);
  // half carry, overflow, carry of a sum
  function automatic logic [2:0] add_hvc(input logic [7:0] x, y, r);
    add_hvc = {x[3] & y[3] | y[3] & ~r[3] | ~r[3] & x[3],
               x[7] & y[7] & ~r[7] | ~x[7] & ~y[7] & r[7],
               x[7] & y[7] | y[7] & ~r[7] | ~r[7] & x[7]};
  endfunction

  // half borrow, overflow, borrow of a difference
  function automatic logic [2:0] sub_hvc(input logic [7:0] x, y, r);
    sub_hvc = {~x[3] & y[3] | y[3] & r[3] | r[3] & ~x[3],
               x[7] & ~y[7] & ~r[7] | ~x[7] & y[7] & r[7],
               ~x[7] & y[7] | y[7] & r[7] | r[7] & ~x[7]};
  endfunction

  logic [2:0] hvc;
  logic [7:0] c8;

  always_comb
  begin
    res = a;
    res_we = 1'b0;
    flag_mask = 8'h00;
    hvc = 3'b000;
    c8 = {7'h00, cin};
    case (op)
      OP_ADD, OP_ADD_CARRY:
      begin
        res = (op == OP_ADD_CARRY) ? a + b + c8 : a + b; // RL5
        res_we = 1'b1;
        hvc = add_hvc(a, b, res);
        flag_mask = MASK_ARITH;
      end
      OP_SUB, OP_SUB_IMM, OP_SUB_CARRY_REG, OP_SUB_CARRY_IMM,
      OP_COMPARE, OP_COMPARE_CARRY, OP_COMPARE_IMM:
      begin
        if (op == OP_SUB_CARRY_REG || op == OP_SUB_CARRY_IMM ||
            op == OP_COMPARE_CARRY)
          res = a - b - c8; // RL7
        else
          res = a - b;
        res_we = (op != OP_COMPARE) && (op != OP_COMPARE_CARRY) &&
                 (op != OP_COMPARE_IMM); // RL8
        hvc = sub_hvc(a, b, res);
        flag_mask = MASK_ARITH;
      end
      OP_AND, OP_AND_IMM, OP_OR, OP_OR_IMM, OP_XOR, OP_CLEAR_BITS_MASK:
      begin
        case (op)
          OP_AND, OP_AND_IMM: res = a & b;
          OP_OR, OP_OR_IMM: res = a | b;
          OP_XOR: res = a ^ b;
          default: res = a & (8'hff - b); // RL10
        endcase
        res_we = 1'b1;
        flag_mask = MASK_LOGIC; // RL9
      end
      OP_ROTATE_RIGHT_CARRY, OP_ARITH_SHIFT_RIGHT:
      begin
        res = (op == OP_ROTATE_RIGHT_CARRY) ? {cin, a[7:1]} // RL17
                                            : {a[7], a[7:1]}; // RL20
        res_we = 1'b1;
        hvc = {1'b0, res[7] ^ a[0], a[0]};
        flag_mask = MASK_SHIFT;
      end
      default: ;
    endcase
    flag_val = 8'h00;
    flag_val[SF_H] = hvc[2];
    flag_val[SF_V] = hvc[1];
    flag_val[SF_C] = hvc[0];
    flag_val[SF_N] = res[7];
    flag_val[SF_Z] = (res == 8'h00);
  end
endmodule
`default_nettype wire

// ==== verilog/cie_core.sv ====
// Design decisions made here: the APB interface to the registers and the address map.
`default_nettype none
// Summary of operation
// RL1: software writes reserved bits as zero and never writes reserved i/o.
// RL2: i/o 0x00-0x1f allow single-bit set, clear and test-and-skip.
// RL3: single-bit set/clear touch only the addressed bit, no write-back.
// RL4: i/o addresses 0x00-0x3f appear in data space at address plus 0x20.
// RL5: add and add_carry write sum, update Z C N V H, one clock.
// RL6: add_imm_word/sub_imm_word work on a 16-bit pair, Z C N V S, two clocks.
// RL7: sub_carry_reg/imm subtract operand and carry, Z C N V H, one clock.
// RL8: compares set Z N V C H only, dest_reg kept, one clock.
// RL9: and, or, xor update Z N V only, carry kept, one clock.
// RL10: clear_bits_mask ands dest_reg with 0xff minus the mask.
// RL11: compare_skip_equal skips next when equal, pc plus 2 or 3, 1/2/3 clocks.
// RL12: register and i/o bit skips test one bit, skip on polarity, 1/2/3.
// RL13: flag branches load pc+k+1 when flag matches; one or two clocks.
// RL14: branch_signed_ge taken when N xor V is zero.
// RL15: relative jump 2, call 3; indirect from Z pointer, jump 2, call 3.
// RL16: i/o bit set/clear write the bit, two clocks, flags unchanged.
// RL17: rotate_right_carry: carry into bit 7, bit 0 into carry, one clock.
// RL18: bit_to_tflag copies bit to T; tflag_to_bit copies T back, no flags.
// RL19: flag set/clear change only that status_flag_register bit, one clock.
// RL20: arith_shift_right keeps bit 7, shifts down, bit 0 into carry.
module cie_core
  import cie_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [7:0] io_event,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0] gpr_ff [0:31];
  logic [7:0] io_ff [0:63];
  logic [7:0] flag_ff;
  logic [15:0] pc_ff;
  logic [15:0] ret_ff;
  logic [31:0] cmd_ff;
  cie_state_e state_ff;
  logic [1:0] wait_ff;
  logic [1:0] last_clk_ff;
  logic flow_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  // pc plus signed offset plus one
  function automatic logic [15:0] rel_target(input logic [15:0] pc,
                                             input logic [7:0] k);
    rel_target = pc + {{8{k[7]}}, k} + 16'h0001;
  endfunction

  // flags of a 16-bit pair add or subtract
  function automatic logic [7:0] word_flags(input logic sub,
                                            input logic [15:0] x,
                                            input logic [15:0] r);
    logic v;
    logic c;
    v = sub ? (x[15] & ~r[15]) : (~x[15] & r[15]);
    c = sub ? (r[15] & ~x[15]) : (~r[15] & x[15]);
    word_flags = 8'h00;
    word_flags[SF_V] = v;
    word_flags[SF_C] = c;
    word_flags[SF_N] = r[15];
    word_flags[SF_S] = r[15] ^ v;
    word_flags[SF_Z] = (r == 16'h0000);
  endfunction

  function automatic logic is_io_bit_op(input cie_op_e op);
    is_io_bit_op = (op == OP_IO_BIT_SET) || (op == OP_IO_BIT_CLEAR) ||
                   (op == OP_SKIP_IO_BIT_CLEAR) || (op == OP_SKIP_IO_BIT_SET);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic access;
  logic wr;
  logic rd;
  logic in_data;
  logic [6:0] d_idx;
  logic addr_ok;
  logic cmd_ok;
  logic cmd_go;
  logic d_gpr_we;
  logic d_io_we;
  logic [5:0] d_io_addr;
  logic [31:0] rdata;

  assign access = psel && penable && !pready_ff &&
                  (state_ff == ST_IDLE || (!pwrite && paddr == REG_STATUS));
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign in_data = (paddr[11:10] == DATA_WIN_SEL) && !paddr[9] &&
                   (paddr[8:2] <= DATA_TOP) && (paddr[1:0] == 2'b00);
  assign d_idx = paddr[8:2];
  assign d_io_addr = 6'(d_idx - DATA_IO_OFFSET); // RL4
  assign d_gpr_we = wr && in_data && (d_idx < DATA_IO_OFFSET);
  assign d_io_we = wr && in_data && (d_idx >= DATA_IO_OFFSET); // RL4
  assign addr_ok = in_data || paddr == REG_CMD || paddr == REG_STATUS ||
                   paddr == REG_PC || paddr == REG_FLAG || paddr == REG_RET;

  ////////////////////////////////////////////////////////////////////////////
  // command fields and operands

  cie_op_e f_op;
  logic [4:0] f_rd;
  logic [4:0] f_rd_hi;
  logic [4:0] f_rs;
  logic [7:0] f_imm;
  logic [2:0] f_bit;
  logic f_long;
  logic [5:0] f_io;
  logic [7:0] op_a;
  logic [7:0] op_r;
  logic [7:0] alu_b;
  logic [15:0] pair;
  logic [15:0] word_res;

  assign f_op = cie_op_e'(pwdata[CMD_OP_LSB +: 6]);
  assign f_rd = pwdata[CMD_RD_LSB +: 5];
  assign f_rd_hi = f_rd + 5'd1;
  assign f_rs = pwdata[CMD_RS_LSB +: 5];
  assign f_imm = pwdata[CMD_IMM_LSB +: 8];
  assign f_bit = pwdata[CMD_BIT_LSB +: 3];
  assign f_long = pwdata[CMD_LONG_POS];
  assign f_io = f_imm[5:0];
  assign op_a = gpr_ff[f_rd];
  assign op_r = gpr_ff[f_rs];
  assign alu_b = (f_op == OP_SUB_IMM || f_op == OP_SUB_CARRY_IMM ||
                  f_op == OP_COMPARE_IMM || f_op == OP_AND_IMM ||
                  f_op == OP_OR_IMM || f_op == OP_CLEAR_BITS_MASK)
                 ? f_imm : op_r;
  assign pair = {gpr_ff[f_rd_hi], op_a};
  assign word_res = (f_op == OP_SUB_IMM_WORD) ? pair - {10'h000, f_io}
                                              : pair + {10'h000, f_io}; // RL6
  assign cmd_ok = (pwdata[CMD_OP_LSB +: 6] <= OP_LAST) &&
                  (!is_io_bit_op(f_op) || f_io <= IO_BIT_MAX); // RL2
  assign cmd_go = wr && paddr == REG_CMD && cmd_ok;

  logic [7:0] alu_res;
  logic alu_we;
  logic [7:0] alu_mask;
  logic [7:0] alu_val;

  cie_alu u_alu (
    .op(f_op),
    .a(op_a),
    .b(alu_b),
    .cin(flag_ff[SF_C]),
    .res(alu_res),
    .res_we(alu_we),
    .flag_mask(alu_mask),
    .flag_val(alu_val)
  );

  ////////////////////////////////////////////////////////////////////////////
  // execute

  logic [15:0] x_pc;
  logic [1:0] x_clk;
  logic x_flow;
  logic [7:0] x_flag;
  logic x_lo_we;
  logic [7:0] x_lo_data;
  logic x_hi_we;
  logic x_io_we;
  logic x_io_val;
  logic x_ret_we;
  logic skip_en;
  logic br_en;
  logic cond;

  always_comb
  begin
    x_pc = pc_ff + 16'h0001;
    x_clk = CLK_ONE;
    x_flow = 1'b0;
    x_flag = (flag_ff & ~alu_mask) | (alu_val & alu_mask);
    x_lo_we = alu_we;
    x_lo_data = alu_res;
    x_hi_we = 1'b0;
    x_io_we = 1'b0;
    x_io_val = 1'b0;
    x_ret_we = 1'b0;
    skip_en = 1'b0;
    br_en = 1'b0;
    cond = 1'b0;
    case (f_op)
      OP_ADD_IMM_WORD, OP_SUB_IMM_WORD:
      begin
        x_lo_we = 1'b1;
        x_lo_data = word_res[7:0];
        x_hi_we = 1'b1;
        x_clk = CLK_TWO;
        x_flag = (flag_ff & ~MASK_WORD) |
                 (word_flags(f_op == OP_SUB_IMM_WORD, pair, word_res) &
                  MASK_WORD); // RL6
      end
      OP_COMPARE_SKIP_EQUAL:
      begin
        skip_en = 1'b1;
        cond = (op_a == op_r); // RL11
      end
      OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET:
      begin
        skip_en = 1'b1;
        cond = op_r[f_bit] == (f_op == OP_SKIP_REG_BIT_SET); // RL12
      end
      OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET:
      begin
        skip_en = 1'b1;
        cond = io_ff[f_io][f_bit] == (f_op == OP_SKIP_IO_BIT_SET); // RL2 RL12
      end
      OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR:
      begin
        br_en = 1'b1;
        cond = flag_ff[f_bit] == (f_op == OP_BRANCH_FLAG_SET); // RL13
      end
      OP_BRANCH_SIGNED_GE:
      begin
        br_en = 1'b1;
        cond = (flag_ff[SF_N] ^ flag_ff[SF_V]) == 1'b0; // RL14
      end
      OP_RELATIVE_JUMP, OP_RELATIVE_CALL:
      begin
        x_pc = rel_target(pc_ff, f_imm); // RL15
        x_clk = (f_op == OP_RELATIVE_CALL) ? CLK_THREE : CLK_TWO;
        x_ret_we = (f_op == OP_RELATIVE_CALL);
      end
      OP_INDIRECT_JUMP, OP_INDIRECT_CALL:
      begin
        x_pc = {gpr_ff[31], gpr_ff[30]}; // RL15
        x_clk = (f_op == OP_INDIRECT_CALL) ? CLK_THREE : CLK_TWO;
        x_ret_we = (f_op == OP_INDIRECT_CALL);
      end
      OP_IO_BIT_SET, OP_IO_BIT_CLEAR:
      begin
        x_io_we = 1'b1;
        x_io_val = (f_op == OP_IO_BIT_SET);
        x_clk = CLK_TWO; // RL16
      end
      OP_BIT_TO_TFLAG:
        x_flag[SF_T] = op_r[f_bit]; // RL18
      OP_TFLAG_TO_BIT:
      begin
        x_lo_we = 1'b1;
        x_lo_data = op_a;
        x_lo_data[f_bit] = flag_ff[SF_T]; // RL18
      end
      OP_FLAG_SET, OP_FLAG_CLEAR:
        x_flag[f_bit] = (f_op == OP_FLAG_SET); // RL19
      default: ;
    endcase
    if (skip_en && cond)
    begin
      x_pc = pc_ff + (f_long ? 16'h0003 : 16'h0002); // RL11 RL12
      x_clk = f_long ? CLK_THREE : CLK_TWO;
      x_flow = 1'b1;
    end
    if (br_en && cond)
    begin
      x_pc = rel_target(pc_ff, f_imm); // RL13
      x_clk = CLK_TWO;
      x_flow = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cycle sequencing

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= ST_IDLE;
      wait_ff <= 2'b00;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
          if (cmd_go && x_clk != CLK_ONE)
          begin
            state_ff <= ST_BUSY;
            wait_ff <= x_clk - CLK_ONE; // RL6 RL15 RL16
          end
        ST_BUSY:
        begin
          wait_ff <= wait_ff - 2'b01;
          if (wait_ff == 2'b01)
            state_ff <= ST_IDLE;
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // working registers

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 32; i++)
        gpr_ff[i] <= 8'h00;
    end
    else
    begin
      if (d_gpr_we)
        gpr_ff[d_idx[4:0]] <= pwdata[7:0];
      if (cmd_go && x_lo_we)
        gpr_ff[f_rd] <= x_lo_data; // RL5 RL7 RL9
      if (cmd_go && x_hi_we)
        gpr_ff[f_rd_hi] <= word_res[15:8]; // RL6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // i/o space

  always_ff @(posedge pclk or negedge presetn)
  begin
    logic [7:0] nxt;
    if (!presetn)
    begin
      for (int i = 0; i < 64; i++)
        io_ff[i] <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < 64; i++)
      begin
        nxt = io_ff[i];
        if (d_io_we && d_io_addr == 6'(i))
          nxt = (6'(i) == IO_FLAG_ADDR) ? nxt & ~pwdata[7:0] : pwdata[7:0];
        if (cmd_go && x_io_we && f_io == 6'(i))
          nxt[f_bit] = x_io_val; // RL3 RL16
        if (6'(i) == IO_FLAG_ADDR)
          nxt = nxt | io_event;
        io_ff[i] <= nxt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program counter, flags, call return

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_ff <= PC_RST;
      flag_ff <= FLAG_RST;
      ret_ff <= PC_RST;
      cmd_ff <= CMD_RST;
      last_clk_ff <= 2'b00;
      flow_ff <= 1'b0;
    end
    else if (cmd_go)
    begin
      pc_ff <= x_pc;
      flag_ff <= x_flag; // RL16 RL19
      if (x_ret_we)
        ret_ff <= pc_ff + 16'h0001;
      cmd_ff <= pwdata;
      last_clk_ff <= x_clk;
      flow_ff <= x_flow;
    end
    else if (wr && paddr == REG_PC)
      pc_ff <= pwdata[15:0];
    else if (wr && paddr == REG_FLAG)
      flag_ff <= pwdata[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer

  always_comb
  begin
    rdata = 32'h0000_0000;
    if (in_data)
      rdata[7:0] = (d_idx < DATA_IO_OFFSET) ? gpr_ff[d_idx[4:0]]
                                            : io_ff[d_io_addr];
    else
      case (paddr)
        REG_CMD: rdata = cmd_ff;
        REG_STATUS: rdata[5:0] = {last_clk_ff, 2'b00, flow_ff,
                                  state_ff == ST_BUSY};
        REG_PC: rdata[15:0] = pc_ff;
        REG_FLAG: rdata[7:0] = flag_ff;
        REG_RET: rdata[15:0] = ret_ff;
        default: rdata = 32'h0000_0000;
      endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end
    else
    begin
      pready_ff <= access;
      pslverr_ff <= access && (!addr_ok || (pwrite && paddr == REG_CMD &&
                                            !cmd_ok));
      prdata_ff <= (rd && addr_ok) ? rdata : 32'h0000_0000;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;

endmodule
`default_nettype wire

// ==== tb/cie_event_model.sv ====
`default_nettype none
module cie_event_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] req,
  output logic [7:0] io_event
);
  timeunit 1ns;
  timeprecision 1ns;
  // event source: raises each requested line one cycle later, for as long as it is requested
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      io_event <= 8'h00;
    else
      io_event <= req;
  end
endmodule
`default_nettype wire

// ==== tb/cie_core_assertions.sv ====
`default_nettype none
module cie_core_assertions
  import cie_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_ready_source: assert property (pready |-> psel && penable &&
    $past(psel))
    else $error("pready outside an access phase");
  a_ready_bound: assert property (psel && penable && !pready |->
    ##[1:4] pready)
    else $error("access phase not answered in time");
  a_status_fast: assert property (psel && penable && !pwrite &&
    paddr == REG_STATUS && !pready |=> pready)
    else $error("status read not answered next cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  a_addr_err: assert property (pready && (paddr[1:0] != 2'h0 ||
    (paddr > REG_RET && paddr < 12'h400)) |-> pslverr)
    else $error("bad address not refused");
  a_io_refuse: assert property (pready && pwrite && paddr == REG_CMD &&
    pwdata[5:0] inside {6'h16, 6'h17, 6'h1f, 6'h20} &&
    pwdata[21:16] > IO_BIT_MAX |-> pslverr)
    else $error("i/o bit op above 0x1f not refused");
  a_pc_ok: assert property (pready && paddr == REG_PC |-> !pslverr)
    else $error("pc access refused");
endmodule
bind cie_core cie_core_assertions u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ==== tb/test_cie_core.sv ====
`default_nettype none
module test_cie_core
  import cie_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] io_event, ev_req;
  int bad_count, check_count;
  always #50 pclk = ~pclk;
  cie_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .io_event(io_event), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  cie_event_model u_ev (.pclk(pclk), .presetn(presetn), .req(ev_req),
    .io_event(io_event));
  //////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    if (bad_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] wd, output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      bad_count++;
      $display("MISMATCH %0t no pready", $time);
      conclude();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    xfer(1'b0, a, 32'h0, q, e);
  endtask
  task automatic er(input logic [11:0] a, input logic w,
    input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(w, a, d, q, e);
    chk({31'h0, e}, 32'h1);
  endtask
  function automatic logic [11:0] dadr(input int n);
    return 12'h400 + {3'h0, n[6:0], 2'h0};
  endfunction
  function automatic logic [31:0] c(input cie_op_e op, input int d,
    input int s, input int k, input int b, input int l);
    return {4'h0, l[0], b[2:0], k[7:0], s[4:0], d[4:0], op};
  endfunction
  task automatic sr(input int n, input int v);
    wr(dadr(n), 32'(v));
  endtask
  task automatic fl(input int v);
    wr(REG_FLAG, 32'(v));
  endtask
  task automatic ex(input logic [31:0] cw, input logic [11:0] a,
    input int v, input int s, input int k);
    logic [31:0] q;
    wr(REG_CMD, cw);
    rd(a, q);
    chk(q, 32'(v));
    rd(REG_FLAG, q);
    chk(q, 32'(s));
    rd(REG_STATUS, q);
    chk({30'h0, q[5:4]}, 32'(k));
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [31:0] q;
    rd(REG_PC, q);
    chk(q, 32'h0);
    rd(REG_FLAG, q);
    chk(q, 32'h0);
    er(12'h002, 1'b0, 32'h0);
    er(12'h100, 1'b0, 32'h0);
  endtask
  task automatic t_arith;
    sr(1, 'h7f);
    sr(2, 1);
    fl(0);
    ex(c(OP_ADD, 1, 2, 0, 0, 0), dadr(1), 'h80, 'h2c, 1);
    fl(1);
    ex(c(OP_ADD_CARRY, 1, 2, 0, 0, 0), dadr(1), 'h82, 'h04, 1);
    sr(3, 'h10);
    sr(4, 1);
    fl(1);
    ex(c(OP_SUB_CARRY_REG, 3, 4, 0, 0, 0), dadr(3), 'h0e, 'h20, 1);
    fl(1);
    ex(c(OP_SUB_CARRY_IMM, 3, 0, 'h0f, 0, 0), dadr(3), 'hfe, 'h25, 1);
    ex(c(OP_COMPARE_IMM, 3, 0, 'hfe, 0, 0), dadr(3), 'hfe, 'h02, 1);
    ex(c(OP_COMPARE_CARRY, 3, 4, 0, 0, 0), dadr(3), 'hfe, 'h04, 1);
  endtask
  task automatic t_logic;
    sr(5, 'hf0);
    fl(1);
    ex(c(OP_AND_IMM, 5, 0, 'h80, 0, 0), dadr(5), 'h80, 'h05, 1);
    ex(c(OP_CLEAR_BITS_MASK, 5, 0, 'h80, 0, 0), dadr(5), 0, 'h03, 1);
    ex(c(OP_OR, 5, 1, 0, 0, 0), dadr(5), 'h82, 'h05, 1);
    ex(c(OP_XOR, 5, 1, 0, 0, 0), dadr(5), 0, 'h03, 1);
    sr(24, 'hff);
    sr(25, 0);
    fl(0);
    ex(c(OP_ADD_IMM_WORD, 24, 0, 1, 0, 0), dadr(25), 1, 0, 2);
    ex(c(OP_SUB_IMM_WORD, 24, 0, 1, 0, 0), dadr(24), 'hff, 0, 2);
  endtask
  task automatic t_shift;
    sr(6, 'h81);
    fl(0);
    ex(c(OP_ROTATE_RIGHT_CARRY, 6, 6, 0, 0, 0), dadr(6), 'h40, 'h09, 1);
    ex(c(OP_ROTATE_RIGHT_CARRY, 6, 6, 0, 0, 0), dadr(6), 'ha0, 'h0c, 1);
    sr(7, 'h81);
    fl(0);
    ex(c(OP_ARITH_SHIFT_RIGHT, 7, 7, 0, 0, 0), dadr(7), 'hc0, 'h05, 1);
  endtask
  task automatic t_branch;
    logic [31:0] q;
    fl('h04);
    wr(REG_PC, 32'h10);
    ex(c(OP_BRANCH_SIGNED_GE, 0, 0, 5, 0, 0), REG_PC, 'h11, 'h04, 1);
    fl('h0c);
    ex(c(OP_BRANCH_SIGNED_GE, 0, 0, 5, 0, 0), REG_PC, 'h17, 'h0c, 2);
    ex(c(OP_BRANCH_FLAG_SET, 0, 0, 'hfe, 2, 0), REG_PC, 'h16, 'h0c, 2);
    rd(REG_STATUS, q);
    chk({31'h0, q[1]}, 32'h1);
    ex(c(OP_BRANCH_FLAG_CLEAR, 0, 0, 5, 2, 0), REG_PC, 'h17, 'h0c, 1);
    wr(REG_PC, 32'h20);
    ex(c(OP_RELATIVE_CALL, 0, 0, 3, 0, 0), REG_PC, 'h24, 'h0c, 3);
    rd(REG_RET, q);
    chk(q, 32'h21);
    sr(30, 'h40);
    sr(31, 0);
    ex(c(OP_INDIRECT_JUMP, 0, 0, 0, 0, 0), REG_PC, 'h40, 'h0c, 2);
    ex(c(OP_RELATIVE_JUMP, 0, 0, 'hf0, 0, 0), REG_PC, 'h31, 'h0c, 2);
    ex(c(OP_INDIRECT_CALL, 0, 0, 0, 0, 0), REG_PC, 'h40, 'h0c, 3);
    rd(REG_RET, q);
    chk(q, 32'h32);
  endtask
  task automatic t_skip;
    sr(8, 'h55);
    sr(9, 'h55);
    fl(0);
    wr(REG_PC, 32'h30);
    ex(c(OP_COMPARE_SKIP_EQUAL, 8, 9, 0, 0, 1), REG_PC, 'h33, 0, 3);
    sr(9, 'h54);
    ex(c(OP_COMPARE_SKIP_EQUAL, 8, 9, 0, 0, 1), REG_PC, 'h34, 0, 1);
    ex(c(OP_SKIP_REG_BIT_SET, 8, 8, 0, 0, 0), REG_PC, 'h36, 0, 2);
    ex(c(OP_SKIP_REG_BIT_CLEAR, 8, 8, 0, 0, 0), REG_PC, 'h37, 0, 1);
  endtask
  task automatic t_io;
    logic [31:0] q;
    fl('h2c);
    @(posedge pclk);
    ev_req <= 8'h01;
    @(posedge pclk);
    ev_req <= 8'h00;
    rd(dadr('h30), q);
    chk(q, 32'h01);
    ex(c(OP_IO_BIT_SET, 0, 0, 'h10, 3, 0), dadr('h30), 'h09, 'h2c, 2);
    wr(REG_PC, 32'h50);
    ex(c(OP_SKIP_IO_BIT_SET, 0, 0, 'h10, 3, 0), REG_PC, 'h52, 'h2c, 2);
    ex(c(OP_IO_BIT_CLEAR, 0, 0, 'h10, 3, 0), dadr('h30), 1, 'h2c, 2);
    ex(c(OP_SKIP_IO_BIT_CLEAR, 0, 0, 'h10, 3, 1), REG_PC, 'h56, 'h2c, 3);
    er(REG_CMD, 1'b1, c(OP_IO_BIT_SET, 0, 0, 'h20, 0, 0));
    rd(dadr('h40), q);
    chk(q, 32'h0);
    er(REG_CMD, 1'b1, 32'h25);
  endtask
  task automatic t_flag;
    fl(0);
    ex(c(OP_FLAG_SET, 0, 0, 0, 7, 0), dadr(0), 0, 'h80, 1);
    ex(c(OP_FLAG_CLEAR, 0, 0, 0, 7, 0), dadr(0), 0, 0, 1);
    ex(c(OP_FLAG_SET, 0, 0, 0, 0, 0), dadr(0), 0, 'h01, 1);
    sr(10, 'h08);
    sr(11, 0);
    ex(c(OP_BIT_TO_TFLAG, 10, 10, 0, 3, 0), dadr(10), 'h08, 'h41, 1);
    ex(c(OP_TFLAG_TO_BIT, 11, 11, 0, 0, 0), dadr(11), 'h01, 'h41, 1);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    ev_req = 8'h00;
    bad_count = 0;
    check_count = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_arith();
    t_logic();
    t_shift();
    t_branch();
    t_skip();
    t_io();
    t_flag();
    conclude();
  end
endmodule
`default_nettype wire
